// [rtl/fault_response_policy.sv]
// Fault reaction policy of the gate driver: shutdown scope and fault indicator.
//
// Summary of operation
// R1 - Frequency codes 010 off, 011 off-hold pre-drivers and pump; 1xx no detection.
// R2 - An asserted inhibit input always switches the pre-drivers off.
// R3 - Inhibit reporting at zero sets no flag and keeps the indicator high.
// R4 - Inhibit reporting at one sets the flag and holds the indicator low.
// R5 - SPI error keeps drivers and pump running and holds the indicator low.
// R6 - An OFF reaction resumes operation once the condition disappears.
// R7 - An OFF-hold reaction stays off after the condition disappears.
// R8 - With low-hold, the indicator stays low after the abnormality releases.
// R9 - Without low-hold, the flag self-clears and the indicator returns high.
// R10 - Any all-phase pre-driver shutdown also switches off power and motor relay drives.
// R11 - Phase-only shutdown turns off that phase's gate drives and nothing else.
// R12 - The host clears a latched flag, and the indicator then goes high.
// R13 - A mode change during an active abnormality waits for release and clear.
// R14 - Sources are independent and their shutdown requests are ORed together.
`timescale 1ns/1ps
module fault_response_policy (
	input  wire logic                            CORE_CLK_I,
	input  wire logic                            NRST_I,
	input  wire logic                            FREQ_ABN_I,
	input  wire logic                            INHIBIT_I,
	input  wire logic                            SPI_ERR_I,
	input  wire logic [fault_pkg::PHASES-1:0]    PHASE_OFF_REQ_I,
	input  wire logic [fault_pkg::MODE_W-1:0]    FREQ_MODE_I,
	input  wire logic                            INHIBIT_REPORT_I,
	input  wire logic                            FREQ_FLAG_CLR_I,
	input  wire logic                            INHIBIT_FLAG_CLR_I,
	input  wire logic                            SPI_FLAG_CLR_I,
	output logic                                 FREQ_FLAG_O,
	output logic                                 INHIBIT_FLAG_O,
	output logic                                 SPI_FLAG_O,
	output logic                                 FAULT_INDICATOR_N_O,
	output logic      [fault_pkg::PHASES-1:0]    PREDRV_HS_EN_O,
	output logic      [fault_pkg::PHASES-1:0]    PREDRV_LS_EN_O,
	output logic                                 RELAY_PWR_EN_O,
	output logic                                 RELAY_MOT_EN_O,
	output logic                                 CHARGE_PUMP_EN_O,
	output logic                                 DIVIDER_EN_O
);
	import fault_pkg::*;

	// Detector levels arriving from analogue comparators are asynchronous.
	logic [1:0] pin_sync;
	wire        freq_sync = pin_sync[0];
	wire        inh_sync  = pin_sync[1];

	fault_pin_sync #(
		.W (2)
	) u_pin_sync (
		.clk_i   (CORE_CLK_I),
		.nrst_i  (NRST_I),
		.async_i ({INHIBIT_I, FREQ_ABN_I}),
		.sync_o  (pin_sync)
	);

	// Frequency reaction decode.
	wire    freq_nodet = FREQ_MODE_I[MODE_NODET_BIT];                       // see R1
	wire    freq_hold  = !freq_nodet && (FREQ_MODE_I == FREQ_CP_HOLD);      // see R1
	wire    freq_off   = !freq_nodet && (FREQ_MODE_I == FREQ_CP_OFF ||
		FREQ_MODE_I == FREQ_PD_OFF);
	wire    freq_cp    = (FREQ_MODE_I == FREQ_CP_OFF) || (FREQ_MODE_I == FREQ_CP_HOLD);
	react_t freq_react;
	assign  freq_react = freq_nodet ? REACT_NODET :
		freq_hold ? REACT_HOLD :
		freq_off ? REACT_OFF : REACT_CONT;

	// Per-source settings, one slot each.
	logic   [NSRC-1:0] det_vec;
	logic   [NSRC-1:0] clr_vec;
	react_t            react_arr [NSRC];
	logic   [NSRC-1:0] cp_vec;
	logic   [NSRC-1:0] lhold_vec;
	logic   [NSRC-1:0] report_vec;
	logic   [NSRC-1:0] flag_vec;
	logic   [NSRC-1:0] off_vec;
	logic   [NSRC-1:0] cp_off_vec;

	assign det_vec[SRC_FREQ]    = freq_sync;
	assign clr_vec[SRC_FREQ]    = FREQ_FLAG_CLR_I;
	assign react_arr[SRC_FREQ]  = freq_react;
	assign cp_vec[SRC_FREQ]     = freq_cp;
	assign lhold_vec[SRC_FREQ]  = 1'b1;
	assign report_vec[SRC_FREQ] = !freq_nodet;                              // see R1

	// Inhibit always stops the pre-drivers; only the reporting is selectable.
	assign det_vec[SRC_INH]     = inh_sync;
	assign clr_vec[SRC_INH]     = INHIBIT_FLAG_CLR_I;
	assign react_arr[SRC_INH]   = REACT_OFF;                                // see R2
	assign cp_vec[SRC_INH]      = 1'b0;
	assign lhold_vec[SRC_INH]   = 1'b1;                                     // see R4
	assign report_vec[SRC_INH]  = INHIBIT_REPORT_I;                         // see R3, R4

	// An SPI error is a one-cycle event from same-clock framing logic.
	assign det_vec[SRC_SPI]     = SPI_ERR_I;
	assign clr_vec[SRC_SPI]     = SPI_FLAG_CLR_I;
	assign react_arr[SRC_SPI]   = REACT_CONT;                               // see R5
	assign cp_vec[SRC_SPI]      = 1'b0;
	assign lhold_vec[SRC_SPI]   = 1'b1;                                     // see R5
	assign report_vec[SRC_SPI]  = 1'b1;

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : gen_src
			fault_src_if src_if ();

			assign src_if.det    = det_vec[gi];
			assign src_if.clr    = clr_vec[gi];
			assign src_if.react  = react_arr[gi];
			assign src_if.cp     = cp_vec[gi];
			assign src_if.lhold  = lhold_vec[gi];
			assign src_if.report = report_vec[gi];
			assign flag_vec[gi]   = src_if.flag;
			assign off_vec[gi]    = src_if.off;
			assign cp_off_vec[gi] = src_if.cp_off;

			fault_source u_src (
				.clk_i  (CORE_CLK_I),
				.nrst_i (NRST_I),
				.src    (src_if.source)
			);
		end
	endgenerate

	// Combined shutdown requests of every active source.
	wire                pd_all_off = |off_vec || inh_sync;                  // see R2, R14
	wire                cp_off     = |cp_off_vec;                           // see R1, R14
	wire [PHASES-1:0]   phase_off  = PHASE_OFF_REQ_I | {PHASES{pd_all_off}}; // see R11
	wire [PHASES-1:0]   gate_next  = ~phase_off;
	wire                relay_next = !pd_all_off;                           // see R10
	wire                cp_next    = !cp_off;
	wire                ind_next   = !(|flag_vec);                          // see R12, R14

	logic [PHASES-1:0]  hs_reg;
	logic [PHASES-1:0]  ls_reg;
	logic               relay_reg;
	logic               cp_reg;
	logic               ind_n_reg;

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			hs_reg    <= {PHASES{RST_EN}};
			ls_reg    <= {PHASES{RST_EN}};
			relay_reg <= RST_EN;
			cp_reg    <= RST_EN;
			ind_n_reg <= RST_IND_N;
		end else begin
			hs_reg    <= gate_next;
			ls_reg    <= gate_next;
			relay_reg <= relay_next;
			cp_reg    <= cp_next;
			ind_n_reg <= ind_next;
		end
	end

	// The divider shares the charge pump's shutdown scope.
	assign PREDRV_HS_EN_O      = hs_reg;
	assign PREDRV_LS_EN_O      = ls_reg;
	assign RELAY_PWR_EN_O      = relay_reg;
	assign RELAY_MOT_EN_O      = relay_reg;
	assign CHARGE_PUMP_EN_O    = cp_reg;
	assign DIVIDER_EN_O        = cp_reg;
	assign FAULT_INDICATOR_N_O = ind_n_reg;
	assign FREQ_FLAG_O         = flag_vec[SRC_FREQ];
	assign INHIBIT_FLAG_O      = flag_vec[SRC_INH];
	assign SPI_FLAG_O          = flag_vec[SRC_SPI];

	freq_pump_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R1
		(freq_sync && !flag_vec[SRC_FREQ] && (FREQ_MODE_I == FREQ_CP_OFF ||
		FREQ_MODE_I == FREQ_CP_HOLD)) |=> !CHARGE_PUMP_EN_O && !DIVIDER_EN_O &&
		(PREDRV_HS_EN_O == '0))
		else $error("Frequency fault left pump or drivers on.");
	inhibit_pd_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R2
		inh_sync |=> (PREDRV_HS_EN_O == '0) && (PREDRV_LS_EN_O == '0))
		else $error("Inhibit did not stop the pre-drivers.");
	spi_err_run_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R5
		(SPI_ERR_I && !FREQ_ABN_I && !INHIBIT_I && off_vec == '0 && !inh_sync &&
		PHASE_OFF_REQ_I == '0) |-> ##2 !FAULT_INDICATOR_N_O)
		else $error("SPI error did not pull the indicator low.");
	spi_no_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R5
		flag_vec[SRC_SPI] |-> !off_vec[SRC_SPI] && !cp_off_vec[SRC_SPI])
		else $error("SPI error shut circuits down.");
	relay_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R10
		pd_all_off |=> !RELAY_PWR_EN_O && !RELAY_MOT_EN_O)
		else $error("Pre-driver shutdown left a relay drive on.");
	phase_only_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R11
		(!pd_all_off && !cp_off && PHASE_OFF_REQ_I != '0) |=>
		((PREDRV_HS_EN_O | PREDRV_LS_EN_O) == ~$past(PHASE_OFF_REQ_I)) &&
		RELAY_PWR_EN_O && CHARGE_PUMP_EN_O)
		else $error("Phase-only shutdown reached beyond its phase.");
	clear_release_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R12
		(flag_vec == '0) |=> FAULT_INDICATOR_N_O)
		else $error("Indicator low with no flag set.");
	flag_low_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R8
		(|flag_vec) |=> !FAULT_INDICATOR_N_O)
		else $error("Indicator high while a flag is set.");

	// Shutdown scope and flag setting as seen at the registered outputs.
	pump_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R1
		cp_off |=> !CHARGE_PUMP_EN_O && !DIVIDER_EN_O)
		else $error("Pump shutdown request left the pump running.");

	pump_run_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R5
		!cp_off |=> CHARGE_PUMP_EN_O && DIVIDER_EN_O)
		else $error("Pump stopped with no pump shutdown request.");

	all_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R14
		(|off_vec) |=> (PREDRV_HS_EN_O == '0) && (PREDRV_LS_EN_O == '0))
		else $error("A source shutdown left a gate drive on.");

	phase_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R11
		!pd_all_off |=> (PREDRV_HS_EN_O == ~$past(PHASE_OFF_REQ_I)) &&
		(PREDRV_LS_EN_O == ~$past(PHASE_OFF_REQ_I)))
		else $error("Gate drive of a healthy phase was switched off.");

	relay_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R11
		!pd_all_off |=> RELAY_PWR_EN_O && RELAY_MOT_EN_O)
		else $error("Relay drive off with no all-phase shutdown.");

	inh_relay_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R10
		inh_sync |=> !RELAY_PWR_EN_O && !RELAY_MOT_EN_O)
		else $error("Inhibit left a relay drive on.");

	spi_flag_set_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R5
		SPI_ERR_I |=> SPI_FLAG_O)
		else $error("SPI error did not set its flag.");

	// A clear strobe only takes effect once the source has gone quiet.
	freq_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R12
		(FREQ_FLAG_O && FREQ_FLAG_CLR_I && !freq_sync) |=> !FREQ_FLAG_O)
		else $error("Frequency flag survived a valid clear.");

	inh_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R12
		(INHIBIT_FLAG_O && INHIBIT_FLAG_CLR_I && !inh_sync) |=> !INHIBIT_FLAG_O)
		else $error("Inhibit flag survived a valid clear.");

	spi_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R12
		(SPI_FLAG_O && SPI_FLAG_CLR_I && !SPI_ERR_I) |=> !SPI_FLAG_O)
		else $error("SPI flag survived a valid clear.");

	freq_refused_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R12
		(FREQ_FLAG_O && freq_sync) |=> FREQ_FLAG_O)
		else $error("Frequency flag dropped while its condition is active.");

	inh_refused_a: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I) // see R12
		(INHIBIT_FLAG_O && inh_sync) |=> INHIBIT_FLAG_O)
		else $error("Inhibit flag dropped while the inhibit is active.");
endmodule

// [rtl/fault_pkg.sv]
// Constants and types shared by the fault reaction policy block.
package fault_pkg;

	// Number of abnormality sources and their slots.
	localparam int NSRC     = 3;
	localparam int SRC_FREQ = 0;
	localparam int SRC_INH  = 1;
	localparam int SRC_SPI  = 2;

	// Motor phases and synchroniser depth.
	localparam int PHASES      = 3;
	localparam int SYNC_STAGES = 2;

	// Frequency abnormality reaction code.
	localparam int          MODE_W        = 3;
	localparam int          MODE_NODET_BIT = 2;
	localparam logic [2:0]  FREQ_CONT     = 3'h0;
	localparam logic [2:0]  FREQ_PD_OFF   = 3'h1;
	localparam logic [2:0]  FREQ_CP_OFF   = 3'h2;
	localparam logic [2:0]  FREQ_CP_HOLD  = 3'h3;

	// Reaction applied by one source, Gray coded along continue, off and hold.
	typedef enum logic [1:0] {
		REACT_CONT  = 2'h0,
		REACT_OFF   = 2'h1,
		REACT_HOLD  = 2'h3,
		REACT_NODET = 2'h2
	} react_t;

	// Reset values of the applied settings and of the outputs.
	localparam react_t RST_REACT  = REACT_CONT;
	localparam logic   RST_LHOLD  = 1'b1;
	localparam logic   RST_REPORT = 1'b0;
	localparam logic   RST_CP     = 1'b0;
	localparam logic   RST_FLAG   = 1'b0;
	localparam logic   RST_EN     = 1'b1;
	localparam logic   RST_IND_N  = 1'b1;

endpackage

// [rtl/fault_src_if.sv]
// Signals between the policy top and one abnormality source tracker.
`timescale 1ns/1ps
interface fault_src_if;
	import fault_pkg::*;

	logic   det;
	logic   clr;
	react_t react;
	logic   cp;
	logic   lhold;
	logic   report;
	logic   flag;
	logic   off;
	logic   cp_off;

	modport policy (output det, clr, react, cp, lhold, report, input flag, off, cp_off);
	modport source (input det, clr, react, cp, lhold, report, output flag, off, cp_off);
endinterface

// [rtl/fault_pin_sync.sv]
// Two flip-flop synchroniser for asynchronous detector levels.
`timescale 1ns/1ps
module fault_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	import fault_pkg::*;

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule

// [rtl/fault_source.sv]
// Flag, hold latch and applied reaction of one abnormality source.
`timescale 1ns/1ps
module fault_source (
	input  wire logic  clk_i,
	input  wire logic  nrst_i,
	fault_src_if.source src
);
	import fault_pkg::*;

	react_t react_reg;
	logic   cp_reg;
	logic   lhold_reg;
	logic   report_reg;
	logic   flag_reg;
	logic   hold_reg;

	// A new setting is taken only while the source is released and cleared.
	wire    idle       = !src.det && !flag_reg && !hold_reg;      // see R13
	react_t eff_react;
	assign  eff_react  = idle ? src.react : react_reg;            // see R13
	wire    eff_cp     = idle ? src.cp : cp_reg;
	wire    eff_lhold  = idle ? src.lhold : lhold_reg;
	wire    eff_report = idle ? src.report : report_reg;

	wire detected  = src.det && (eff_react != REACT_NODET);       // see R1
	wire set_flag  = detected && eff_report;                      // see R3, R4
	wire host_clr  = src.clr && !src.det;                         // see R12
	wire clr_flag  = eff_lhold ? host_clr : !src.det;             // see R8, R9
	wire flag_next = set_flag || (flag_reg && !clr_flag);
	wire hold_next = (detected && eff_react == REACT_HOLD) || (hold_reg && !host_clr); // see R7
	wire off_now   = detected && (eff_react == REACT_OFF || eff_react == REACT_HOLD);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			react_reg  <= RST_REACT;
			cp_reg     <= RST_CP;
			lhold_reg  <= RST_LHOLD;
			report_reg <= RST_REPORT;
			flag_reg   <= RST_FLAG;
			hold_reg   <= RST_FLAG;
		end else begin
			react_reg  <= eff_react;
			cp_reg     <= eff_cp;
			lhold_reg  <= eff_lhold;
			report_reg <= eff_report;
			flag_reg   <= flag_next;
			hold_reg   <= hold_next;
		end
	end

	// An OFF reaction lapses with the condition; a hold keeps it until cleared.
	assign src.off    = off_now || hold_reg;                      // see R6, R7
	assign src.cp_off = (off_now || hold_reg) && eff_cp;          // see R1
	assign src.flag   = flag_reg;

	nodet_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R1
		(src.det && eff_react == REACT_NODET) |-> (!src.off || hold_reg) && !set_flag)
		else $error("No-detection code still reacted.");
	silent_inhibit_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R3
		(src.det && !eff_report && !flag_reg) |=> !flag_reg)
		else $error("Flag set while reporting is off.");
	flag_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R4
		(src.det && eff_report && eff_react != REACT_NODET) |=> flag_reg)
		else $error("Reported detection did not set the flag.");
	flag_lhold_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R8
		(flag_reg && lhold_reg && !src.clr) |=> flag_reg)
		else $error("Held flag dropped without a clear.");
	flag_auto_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R9
		(flag_reg && !lhold_reg && !src.det) |=> !flag_reg)
		else $error("Non-hold flag not cleared on recovery.");
	off_resume_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R6
		(!src.det && !hold_reg) |-> !src.off)
		else $error("OFF reaction outlived its condition.");
	hold_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R7
		(hold_reg && !host_clr) |=> hold_reg && src.off)
		else $error("OFF-hold released without a clear.");
	mode_freeze_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R13
		(src.det || flag_reg || hold_reg) |=> react_reg == $past(react_reg))
		else $error("Reaction changed while source active.");
endmodule

// [verif/fault_host_model.sv]
// Host controller model that pulses the latched-flag clear strobes.
`timescale 1ns/1ps
module fault_host_model (
	input  wire logic       clk_i,
	output logic      [2:0] clr_o
);
	initial clr_o = 3'h0;

	// Raises one clear strobe for a single clock cycle, changing only after rising edges.
	task automatic clear(input int idx);
		@(posedge clk_i);
		clr_o[idx] <= 1'h1;
		@(posedge clk_i);
		clr_o[idx] <= 1'h0;
	endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the fault reaction policy block.
`timescale 1ns/1ps
module tb_top;
	import fault_pkg::*;
	logic        clk = 1'h0;
	logic        nrst = 1'h0;
	logic        fabn = 1'h0;
	logic        inh = 1'h0;
	logic        spe = 1'h0;
	logic        rep = 1'h0;
	logic [2:0]  preq = 3'h0;
	logic [2:0]  fmode = 3'h0;
	logic [2:0]  clr;
	logic [2:0]  fl;
	logic [2:0]  hs;
	logic [2:0]  ls;
	logic        ind_n, rpwr, rmot, cp, dv;
	logic [13:0] idle = 14'h07FF;
	int          err_total = 0;
	int          n_compared = 0;
	int          cycles = 0;

	fault_host_model host (.clk_i(clk), .clr_o(clr));

	fault_response_policy uut (
		.CORE_CLK_I(clk), .NRST_I(nrst), .FREQ_ABN_I(fabn), .INHIBIT_I(inh),
		.SPI_ERR_I(spe), .PHASE_OFF_REQ_I(preq), .FREQ_MODE_I(fmode), .INHIBIT_REPORT_I(rep),
		.FREQ_FLAG_CLR_I(clr[SRC_FREQ]), .INHIBIT_FLAG_CLR_I(clr[SRC_INH]),
		.SPI_FLAG_CLR_I(clr[SRC_SPI]), .FREQ_FLAG_O(fl[2]), .INHIBIT_FLAG_O(fl[1]),
		.SPI_FLAG_O(fl[0]), .FAULT_INDICATOR_N_O(ind_n), .PREDRV_HS_EN_O(hs),
		.PREDRV_LS_EN_O(ls), .RELAY_PWR_EN_O(rpwr), .RELAY_MOT_EN_O(rmot),
		.CHARGE_PUMP_EN_O(cp), .DIVIDER_EN_O(dv)
	);

	initial begin
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_total++;
			stop_test();
		end
	end

	function automatic logic [13:0] mk(input logic [2:0] f, input logic i, input logic [2:0] h,
		input logic [2:0] l, input logic r, input logic c);
		return {f, i, h, l, r, r, c, c};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Samples all outputs mid-cycle, then returns on the next rising edge for driving.
	task automatic chk(input logic [13:0] e, input string m);
		@(negedge clk);
		n_compared++;
		if ({fl, ind_n, hs, ls, rpwr, rmot, cp, dv} !== e) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, m,
				{fl, ind_n, hs, ls, rpwr, rmot, cp, dv}, e);
		end
		@(posedge clk);
	endtask

	task automatic t_hold();
		fmode <= FREQ_CP_HOLD;
		fabn <= 1'h1;
		cyc(6);
		chk(mk(3'h4, 1'h0, 3'h0, 3'h0, 1'h0, 1'h0), "hold off");
		fmode <= FREQ_CONT;
		fabn <= 1'h0;
		cyc(6);
		chk(mk(3'h4, 1'h0, 3'h0, 3'h0, 1'h0, 1'h0), "hold kept");
		host.clear(SRC_FREQ);
		cyc(3);
		chk(idle, "hold cleared");
		fabn <= 1'h1;
		cyc(6);
		chk(mk(3'h4, 1'h0, 3'h7, 3'h7, 1'h1, 1'h1), "new mode");
		fabn <= 1'h0;
		cyc(4);
		host.clear(SRC_FREQ);
		cyc(3);
		chk(idle, "mode cleared");
		$display("test hold done");
	endtask

	task automatic t_off();
		fmode <= FREQ_CP_OFF;
		fabn <= 1'h1;
		cyc(6);
		chk(mk(3'h4, 1'h0, 3'h0, 3'h0, 1'h0, 1'h0), "off");
		fabn <= 1'h0;
		cyc(6);
		chk(mk(3'h4, 1'h0, 3'h7, 3'h7, 1'h1, 1'h1), "off resume");
		host.clear(SRC_FREQ);
		cyc(3);
		chk(idle, "off cleared");
		fmode <= 3'h5;
		fabn <= 1'h1;
		cyc(6);
		chk(idle, "no detect");
		fabn <= 1'h0;
		cyc(4);
		$display("test off done");
	endtask

	// Pre-driver-only code: gates and relays stop, the pump keeps running.
	task automatic t_pd_only();
		fmode <= FREQ_PD_OFF;
		fabn <= 1'h1;
		cyc(6);
		chk(mk(3'h4, 1'h0, 3'h0, 3'h0, 1'h0, 1'h1), "pd only off");
		fabn <= 1'h0;
		cyc(6);
		chk(mk(3'h4, 1'h0, 3'h7, 3'h7, 1'h1, 1'h1), "pd only resume");
		host.clear(SRC_FREQ);
		cyc(3);
		chk(idle, "pd only cleared");
		fmode <= FREQ_CONT;
		$display("test pre-driver only done");
	endtask

	task automatic t_inh();
		inh <= 1'h1;
		cyc(6);
		chk(mk(3'h0, 1'h1, 3'h0, 3'h0, 1'h0, 1'h1), "inhibit quiet");
		inh <= 1'h0;
		cyc(5);
		chk(idle, "inhibit gone");
		rep <= 1'h1;
		inh <= 1'h1;
		cyc(6);
		chk(mk(3'h2, 1'h0, 3'h0, 3'h0, 1'h0, 1'h1), "inhibit report");
		host.clear(SRC_INH);
		cyc(1);
		chk(mk(3'h2, 1'h0, 3'h0, 3'h0, 1'h0, 1'h1), "inhibit clear refused");
		inh <= 1'h0;
		cyc(5);
		chk(mk(3'h2, 1'h0, 3'h7, 3'h7, 1'h1, 1'h1), "inhibit held");
		host.clear(SRC_INH);
		cyc(3);
		chk(idle, "inhibit cleared");
		$display("test inhibit done");
	endtask

	task automatic t_spi_phase();
		spe <= 1'h1;
		cyc(1);
		spe <= 1'h0;
		cyc(4);
		chk(mk(3'h1, 1'h0, 3'h7, 3'h7, 1'h1, 1'h1), "spi error");
		host.clear(SRC_SPI);
		cyc(3);
		chk(idle, "spi cleared");
		preq <= 3'h2;
		rep <= 1'h0;
		cyc(3);
		chk(mk(3'h0, 1'h1, 3'h5, 3'h5, 1'h1, 1'h1), "phase only");
		inh <= 1'h1;
		cyc(6);
		chk(mk(3'h0, 1'h1, 3'h0, 3'h0, 1'h0, 1'h1), "combined");
		preq <= 3'h0;
		inh <= 1'h0;
		cyc(5);
		chk(idle, "combined gone");
		$display("test spi and phase done");
	endtask

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		cyc(16);
		nrst <= 1'h1;
		cyc(2);
		chk(idle, "after reset");
		t_hold();
		t_off();
		t_pd_only();
		t_inh();
		t_spi_phase();
		stop_test();
	end
endmodule
